// ==== verilog/sfp_core.v ====
// serial peripheral fifo port: master/slave shifter with tx/rx fifos
// assumes cpu strobes on ref_clk; serial pins asynchronous to ref_clk
//
// Overview of operation
// - words of 8, 16, 32 or 9 bits in both roles
// - master line clock is controller clock divided by 2, 4, 8 or 16
// - polarity and phase bits select the four clock modes
// - master transfer starts on low data write; high written first
// - low write sets holding flag; cleared when loaded into shifter
// - shift in while shifting out; at end set irq, pending, copy data
// - mask suppresses irq; clear strobe clears; unread rx keeps irq
// - slave when select bit set; shifts on external clock edges
// - enabled active-low select gates clock; mid-word release resets shifter
// - master idle drives idle level; slave modes 0 and 2 too
// - slave modes 1 and 3 drive idle level during done, then hold that value; reset pulse or force give idle
// - write-only mode uses tx fifo; rx word overwrites data register
// - write-only irq means tx room; holding means full; busy falls
// - read-only mode starts at switch-on, sending tx register contents
// - read-only master runs until rx fifo full or off
// - mode 00 uses both fifos; holding shows tx full, irq rx data
// - 9-bit word sends leading configured bit; received ninth bit dropped
`timescale 1ns/100ps
`default_nettype none
`include "sfp_regs.vh"
module sfp_core #(
    parameter DEPTH = `SFP_FIFO_DEPTH,
    parameter AW    = `SFP_FIFO_AW
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        controller_on,
    input  wire        slave_select_cfg,
    input  wire        clock_polarity,
    input  wire        clock_phase,
    input  wire [1:0]  word_size,
    input  wire [1:0]  clock_div,
    input  wire [1:0]  fifo_mode,
    input  wire        idle_level,
    input  wire        force_idle,
    input  wire        soft_reset,
    input  wire        irq_mask,
    input  wire        ninth_bit_value,
    input  wire        slave_enable_ctrl,
    input  wire        irq_clear,
    input  wire        serial_data_high_wr,
    input  wire        serial_data_low_wr,
    input  wire [31:0] wr_data,
    input  wire        serial_data_low_rd,
    output reg  [31:0] serial_data_out,
    output reg         tx_holding_full,
    output reg         busy,
    output reg         irq_status,
    output reg         irq_pending_flag,
    output reg         irq,
    input  wire        clk_pin_in,
    output reg         clk_pin_out,
    output reg         clk_pin_oe,
    input  wire        data_in_pin,
    output reg         data_out_pin,
    input  wire        slave_enable_n
);
    // ******************************************************
    // pin synchronisers, two flops before any use
    // ******************************************************
    reg [1:0] sclk_sync;
    reg [1:0] din_sync;
    reg [1:0] sen_sync;
    reg       sclk_prev;
    always @(posedge ref_clk) begin
        if (rst) begin
            sclk_sync <= 2'b00;
            din_sync  <= 2'b00;
            sen_sync  <= 2'b11;
            sclk_prev <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], clk_pin_in};
            din_sync  <= {din_sync[0], data_in_pin};
            sen_sync  <= {sen_sync[0], slave_enable_n};
            sclk_prev <= sclk_sync[1];
        end
    end
    // ******************************************************
    // word length helpers
    // ******************************************************
    function [5:0] bits_of;
        input [1:0] ws;
        begin
            case (ws)
                `SFP_WORD_8:  bits_of = 6'd8;
                `SFP_WORD_16: bits_of = 6'd16;
                `SFP_WORD_32: bits_of = 6'd32;
                default:      bits_of = 6'd9;
            endcase
        end
    endfunction
    wire       is_slave = slave_select_cfg;
    wire       use_tx   = (fifo_mode == `SFP_FIFO_BIDIR) || (fifo_mode == `SFP_FIFO_WRONLY);
    wire       use_rx   = (fifo_mode == `SFP_FIFO_BIDIR) || (fifo_mode == `SFP_FIFO_RDONLY);
    wire [5:0] nbits    = bits_of(word_size);
    // ******************************************************
    // fifos: tx words in, rx words out
    // ******************************************************
    reg  [31:0] hold_word;
    reg         hold_valid;
    reg  [31:0] rx_word;
    reg         rx_push;
    wire        tx_in_ready;
    wire [31:0] tx_head;
    wire        tx_head_valid;
    reg         tx_pop;
    wire [AW:0] tx_count;
    wire        rx_in_ready;
    wire [31:0] rx_head;
    wire        rx_head_valid;
    wire [AW:0] rx_count;
    wire        flush = !controller_on || soft_reset;
    sfp_fifo #(.WIDTH(32), .DEPTH(DEPTH), .AW(AW)) u_tx (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .flush     (flush),
        .in_data   ({hold_word[31:16], wr_data[15:0]}),
        .in_valid  (serial_data_low_wr && use_tx),
        .in_ready  (tx_in_ready),
        .out_data  (tx_head),
        .out_valid (tx_head_valid),
        .out_ready (tx_pop),
        .count     (tx_count)
    );
    sfp_fifo #(.WIDTH(32), .DEPTH(DEPTH), .AW(AW)) u_rx (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .flush     (flush),
        .in_data   (rx_word),
        .in_valid  (rx_push && use_rx),
        .in_ready  (rx_in_ready),
        .out_data  (rx_head),
        .out_valid (rx_head_valid),
        .out_ready (serial_data_low_rd && use_rx),
        .count     (rx_count)
    );
    // ******************************************************
    // data registers and holding word (no-fifo path)
    // ******************************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            hold_word  <= `SFP_DATA_RST;
            hold_valid <= 1'b0;
        end else begin
            if (serial_data_high_wr)
                hold_word[31:16] <= wr_data[15:0];
            if (serial_data_low_wr)
                hold_word[15:0] <= wr_data[15:0];
            // load into shifter wins only when no new write arrives
            if (serial_data_low_wr && !use_tx)
                hold_valid <= 1'b1;
            else if (tx_pop && !use_tx)
                hold_valid <= 1'b0;
        end
    end
    // ******************************************************
    // shift engine: master divider or slave edges
    // ******************************************************
    localparam ST_IDLE = 2'd0;
    localparam ST_SHIFT = 2'd1;
    localparam ST_DONE = 2'd2;
    reg [1:0]  state;
    reg [31:0] shreg;
    reg [5:0]  bitcnt;
    reg [2:0]  divcnt;
    reg        lead_edge;
    reg        hold_last;
    reg [1:0]  m_samp;
    reg [31:0] rxreg;
    wire [2:0] div_max = (3'b001 << clock_div) - 3'b001;
    wire       s_rise = sclk_sync[1] & ~sclk_prev;
    wire       s_fall = ~sclk_sync[1] & sclk_prev;
    wire       s_edge = s_rise | s_fall;
    wire       sen_ok = !slave_enable_ctrl || !sen_sync[1];
    // sample edge is the first edge in modes 0/2, second in 1/3
    wire       s_sample = is_slave && sen_ok &&
                          ((s_rise ^ clock_polarity ^ clock_phase) & s_edge);
    wire       s_launch = is_slave && sen_ok && s_edge && !s_sample;
    // read-only master runs freely until rx fifo full
    wire       rdonly_go = (fifo_mode == `SFP_FIFO_RDONLY) && !is_slave && rx_in_ready
                           && (rx_count < DEPTH - 1);
    wire       m_start = !is_slave && ((use_tx ? tx_head_valid : hold_valid) || rdonly_go);
    wire [31:0] load_word = (fifo_mode == `SFP_FIFO_RDONLY) ? hold_word :
                            (use_tx ? tx_head : hold_word);
    // pack word msb-first into top of shifter; 9-bit puts configured bit first
    function [31:0] align_word;
        input [31:0] w;
        input [1:0]  ws;
        input        b9;
        begin
            case (ws)
                `SFP_WORD_8:  align_word = {w[7:0], 24'h000000};
                `SFP_WORD_16: align_word = {w[15:0], 16'h0000};
                `SFP_WORD_32: align_word = w;
                default:      align_word = {b9, w[7:0], 23'h000000};
            endcase
        end
    endfunction
    wire [31:0] start_word = align_word(load_word, word_size, ninth_bit_value);
    always @(posedge ref_clk) begin
        if (rst || soft_reset || !controller_on) begin
            state        <= ST_IDLE;
            shreg        <= `SFP_DATA_RST;
            bitcnt       <= 6'd0;
            divcnt       <= 3'd0;
            lead_edge    <= 1'b1;
            hold_last    <= 1'b0;
            m_samp       <= 2'b00;
            tx_pop       <= 1'b0;
            rx_push      <= 1'b0;
            rx_word      <= `SFP_DATA_RST;
            clk_pin_out  <= 1'b0;
            clk_pin_oe   <= 1'b0;
            busy         <= 1'b0;
        end else begin
            tx_pop     <= 1'b0;
            rx_push    <= 1'b0;
            // data pin lags two flops; receive shifts once it has arrived
            m_samp     <= {m_samp[0], 1'b0};
            if (m_samp[1])
                rxreg <= {rxreg[30:0], din_sync[1]};
            clk_pin_oe <= !is_slave;
            case (state)
                ST_IDLE: begin
                    clk_pin_out <= clock_polarity;
                    bitcnt      <= 6'd0;
                    divcnt      <= 3'd0;
                    lead_edge   <= 1'b1;
                    busy        <= use_tx ? tx_head_valid : 1'b0;
                    if (m_start || (is_slave && sen_ok)) begin
                        shreg     <= start_word;
                        tx_pop    <= m_start && !(fifo_mode == `SFP_FIFO_RDONLY);
                        state     <= ST_SHIFT;
                        busy      <= !is_slave;
                        hold_last <= 1'b0;
                    end
                end
                ST_SHIFT: begin
                    busy <= 1'b1;
                    if (is_slave && slave_enable_ctrl && sen_sync[1]) begin
                        state  <= ST_IDLE;
                        shreg  <= `SFP_DATA_RST;
                        bitcnt <= 6'd0;
                    end else if (is_slave) begin
                        if (s_sample) begin
                            shreg  <= {shreg[30:0], din_sync[1]};
                            bitcnt <= bitcnt + 6'd1;
                            m_samp[1] <= 1'b1;
                            if (bitcnt + 6'd1 == nbits)
                                state <= ST_DONE;
                        end
                    end else if (divcnt == div_max) begin
                        divcnt      <= 3'd0;
                        clk_pin_out <= ~clk_pin_out;
                        lead_edge   <= ~lead_edge;
                        // sample on leading edge in phase 0, trailing in phase 1
                        if (lead_edge ^ clock_phase) begin
                            shreg  <= {shreg[30:0], din_sync[1]};
                            bitcnt <= bitcnt + 6'd1;
                            m_samp[0] <= 1'b1;
                        end
                        // phase 1 counts its last bit on this same trailing edge
                        if (!lead_edge && bitcnt + {5'd0, clock_phase} == nbits)
                            state <= ST_DONE;
                    end else
                        divcnt <= divcnt + 3'd1;
                end
                ST_DONE: if (m_samp == 2'b00) begin
                    // ninth bit sits at bit 8 and is masked off; low 8 kept
                    rx_word   <= (word_size == `SFP_WORD_32) ? rxreg :
                                 ((word_size == `SFP_WORD_16) ? {16'h0000, rxreg[15:0]} :
                                  {24'h000000, rxreg[7:0]});
                    rx_push   <= 1'b1;
                    hold_last <= clock_phase;
                    state     <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    // ******************************************************
    // data output: idle level, held level, or shifter msb
    // ******************************************************
    always @(posedge ref_clk) begin
        if (rst)
            data_out_pin <= 1'b0;
        else if (force_idle || soft_reset || !controller_on)
            data_out_pin <= idle_level;
        else if (state == ST_SHIFT)
            data_out_pin <= shreg[31];
        else if (state == ST_IDLE && m_start)
            data_out_pin <= start_word[31];
        else if (!(hold_last && is_slave))
            data_out_pin <= idle_level;
    end
    // ******************************************************
    // status, readable data and interrupt
    // ******************************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            serial_data_out  <= `SFP_DATA_RST;
            tx_holding_full  <= 1'b0;
            irq_status       <= 1'b0;
            irq_pending_flag <= 1'b0;
            irq              <= 1'b0;
        end else begin
            // without rx fifo each word overwrites the data register
            if (rx_push && !use_rx)
                serial_data_out <= rx_word;
            else if (use_rx)
                serial_data_out <= rx_head;
            tx_holding_full <= use_tx ? !tx_in_ready : hold_valid;
            // set wins over a clear in the same cycle
            if (rx_push) begin
                irq_status       <= 1'b1;
                irq_pending_flag <= 1'b1;
            end else if (irq_clear) begin
                irq_status       <= 1'b0;
                irq_pending_flag <= 1'b0;
            end
            if (fifo_mode == `SFP_FIFO_WRONLY)
                irq <= !irq_mask && tx_in_ready;
            else
                irq <= !irq_mask && ((irq_status && !(irq_clear && !rx_push))
                       || rx_head_valid);
        end
    end
endmodule // sfp_core
`default_nettype wire

// ==== verilog/sfp_regs.vh ====
// constants for the serial peripheral fifo port
// assumes inclusion by bare name from verilog/ files
`ifndef SFP_REGS_VH
`define SFP_REGS_VH
// word size field encodings
`define SFP_WORD_8        2'b00
`define SFP_WORD_16       2'b01
`define SFP_WORD_32       2'b10
`define SFP_WORD_9        2'b11
// fifo mode field encodings
`define SFP_FIFO_BIDIR    2'b00
`define SFP_FIFO_RDONLY   2'b01
`define SFP_FIFO_WRONLY   2'b10
`define SFP_FIFO_NONE     2'b11
// clock divider field encodings (line clock divide by 2, 4, 8, 16)
`define SFP_DIV_8         2'b11
// reset values and fifo size
`define SFP_DATA_RST      32'h0000_0000
`define SFP_FIFO_DEPTH    16
`define SFP_FIFO_AW       4
`endif

// ==== verilog/sfp_fifo.v ====
// small synchronous fifo with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module sfp_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output reg              in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready,
    output reg  [AW:0]      count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    wire            push = in_valid & in_ready;
    wire            pop  = out_valid & out_ready;
    wire [AW:0]     next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // ******************************************************
    // storage and pointers; read data is registered
    // ******************************************************
    always @(posedge ref_clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
    always @(posedge ref_clk) begin
        if (rst || flush) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            // head word refilled whenever the output slot empties
            if ((!out_valid || pop) && (count != {{AW{1'b0}}, out_valid})) begin
                out_data  <= mem[rd_ptr];
                rd_ptr    <= rd_ptr + 1'b1;
                out_valid <= 1'b1;
            end else if (pop) begin
                out_valid <= 1'b0;
            end
            count    <= next_count;
            in_ready <= (next_count < DEPTH);
        end
    end
endmodule // sfp_fifo
`default_nettype wire

// ==== verif/sfp_core_chk.sv ====
// checker: port relations of sfp_core, bound to every instance
// assumes a synchronous active-high rst on ref_clk
`timescale 1ns/100ps
`default_nettype none
module sfp_chk (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       controller_on,
    input wire logic       slave_select_cfg,
    input wire logic       clock_polarity,
    input wire logic [1:0] fifo_mode,
    input wire logic       idle_level,
    input wire logic       force_idle,
    input wire logic       soft_reset,
    input wire logic       irq_mask,
    input wire logic       irq_clear,
    input wire logic       serial_data_low_wr,
    input wire logic       busy,
    input wire logic       irq_status,
    input wire logic       irq,
    input wire logic       clk_pin_out,
    input wire logic       clk_pin_oe,
    input wire logic       data_out_pin
);
    // ****************
    // relations
    // ****************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // plain master with fifos off; the simplest irq meaning
    wire logic master = !slave_select_cfg;
    wire logic plain  = master && fifo_mode == 2'b11;
    a_idle_data: assert property (master && !busy && !$past(busy) && $stable(idle_level)
        |-> data_out_pin == idle_level) else $error("data line off idle level");
    a_force_hold: assert property (force_idle && $past(force_idle) && $stable(idle_level)
        |-> data_out_pin == idle_level) else $error("forced idle level missing");
    a_clk_idle: assert property (master && !busy && !$past(busy) && $stable(clock_polarity)
        |-> clk_pin_out == clock_polarity) else $error("idle clock level wrong");
    a_slave_oe: assert property (slave_select_cfg && $past(slave_select_cfg)
        |-> !clk_pin_oe) else $error("slave drives the clock pin");
    a_master_oe: assert property (master && busy |-> clk_pin_oe)
        else $error("master clock not driven in a word");
    a_start_word: assert property (plain && controller_on && !busy && serial_data_low_wr
        |-> ##[1:3] busy) else $error("low write did not start a word");
    a_done_irq: assert property (plain && $fell(busy) && controller_on && $past(controller_on)
        && !$past(soft_reset) && !$past(soft_reset, 2) |-> ##[0:2] irq_status)
        else $error("word end without irq status");
    a_clear_irq: assert property ((!busy)[*3] ##0 (irq_clear && plain) |=> !irq_status)
        else $error("clear left irq status set");
    a_mask_irq: assert property (irq_mask && $past(irq_mask) |-> !irq)
        else $error("masked irq reached the cpu");
    a_irq_follow: assert property ((irq_status && !irq_mask && plain)[*2] |-> irq)
        else $error("unmasked irq status not passed on");
    c_word: cover property (master && $fell(busy));
    c_slave: cover property (slave_select_cfg && irq_status);
    c_force: cover property (force_idle && busy);
endmodule // sfp_chk
bind sfp_core sfp_chk sfp_chk_inst (.ref_clk, .rst, .controller_on, .slave_select_cfg,
    .clock_polarity, .fifo_mode, .idle_level, .force_idle, .soft_reset, .irq_mask, .irq_clear,
    .serial_data_low_wr, .busy, .irq_status, .irq, .clk_pin_out, .clk_pin_oe, .data_out_pin);
`default_nettype wire

// ==== verif/sfp_slave_model.sv ====
// partner: serial slave device answering the master, msb first
// assumes the testbench pulses load before each word it expects
`timescale 1ns/100ps
`default_nettype none
module sfp_slave_model (
    input  wire logic        clk_pin_out,
    input  wire logic        clk_pin_oe,
    input  wire logic        data_out_pin,
    input  wire logic        clock_polarity,
    input  wire logic        clock_phase,
    input  wire logic [5:0]  nbits,
    input  wire logic        load,
    input  wire logic [31:0] tx_word,
    output logic             data_in_pin,
    output logic [31:0]      rx_word
);
    int cnt = 32;
    // frame start: first bit ready before the first edge
    always @(posedge load) begin
        cnt = 0;
        rx_word = 32'h0;
        data_in_pin = tx_word[nbits-1];
    end
    // sample on the leading edge in phase 0, trailing in phase 1
    always @(clk_pin_out) begin
        if (clk_pin_oe === 1'b1 && cnt < nbits) begin
            if ((clk_pin_out != clock_polarity) ^ clock_phase) begin
                rx_word = {rx_word[30:0], data_out_pin};
                cnt = cnt + 1;
            end else
                data_in_pin = tx_word[nbits-1-cnt];
        end else
            data_in_pin = ~data_in_pin; // released line keeps no value
    end
endmodule // sfp_slave_model
`default_nettype wire

// ==== verif/sfp_core_tb.sv ====
// testbench: master word table, then force, fifo modes and slave frames
// assumes sfp_core built with a 4-word fifo and the slave model beside it
`timescale 1ns/100ps
`default_nettype none
`include "sfp_regs.vh"
module sfp_core_tb;
    typedef struct packed {logic pol, pha; logic [1:0] ws, div; logic [31:0] tx, sx;} sfp_row_t;
    logic ref_clk = 0, rst = 1, controller_on = 0, slave_select_cfg = 0, clock_polarity = 0;
    logic clock_phase = 0, idle_level = 0, force_idle = 0, soft_reset = 0, irq_mask = 0;
    logic ninth_bit_value = 0, slave_enable_ctrl = 0, irq_clear = 0, serial_data_high_wr = 0;
    logic serial_data_low_wr = 0, serial_data_low_rd = 0, clk_pin_in = 0, slave_enable_n = 1;
    logic [1:0] word_size = 0, clock_div = 0, fifo_mode = `SFP_FIFO_NONE;
    logic [31:0] wr_data = 0, serial_data_out, mtx = 0, mrx, msk, ex;
    logic tx_holding_full, busy, irq_status, irq_pending_flag, irq, clk_pin_out, clk_pin_oe;
    logic data_out_pin, mdin, load = 0, tb_din = 0;
    logic [7:0] got;
    logic [5:0] nb = 6'h08;
    wire logic data_in_pin = slave_select_cfg ? tb_din : mdin;
    int mismatches = 0, checks_done = 0, k, n;
    sfp_row_t r;
    sfp_row_t rows [8] = '{'{0, 0, 2'h0, 2'h0, 32'h5a, 32'hc3},
        '{0, 1, 2'h1, 2'h1, 32'h3cf0, 32'h81e7}, '{1, 0, 2'h2, 2'h2, 32'h1234_5678, 32'h9abc_def0},
        '{1, 1, 2'h3, 2'h3, 32'h96, 32'h169}, '{1, 1, 2'h0, 2'h3, 32'h81, 32'h7e},
        '{0, 1, 2'h2, 2'h0, 32'hf00d_1ee5, 32'h0ff1_ce00}, '{1, 0, 2'h1, 2'h1, 32'h8001, 32'h7ffe},
        '{0, 0, 2'h3, 2'h2, 32'h3b, 32'h0c4}};
    sfp_core #(.DEPTH(4), .AW(2)) sfp_core_inst (.ref_clk, .rst, .controller_on,
        .slave_select_cfg, .clock_polarity, .clock_phase, .word_size, .clock_div, .fifo_mode,
        .idle_level, .force_idle, .soft_reset, .irq_mask, .ninth_bit_value, .slave_enable_ctrl,
        .irq_clear, .serial_data_high_wr, .serial_data_low_wr, .wr_data, .serial_data_low_rd,
        .serial_data_out, .tx_holding_full, .busy, .irq_status, .irq_pending_flag, .irq,
        .clk_pin_in, .clk_pin_out, .clk_pin_oe, .data_in_pin, .data_out_pin, .slave_enable_n);
    sfp_slave_model sfp_slave_model_inst (.clk_pin_out, .clk_pin_oe, .data_out_pin,
        .clock_polarity, .clock_phase, .nbits(nb), .load, .tx_word(mtx), .data_in_pin(mdin),
        .rx_word(mrx));
    // ****************
    // shared tasks
    // ****************
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    task automatic strobe(ref logic s);
        s = 1;
        tick(1);
        s = 0;
    endtask
    task automatic wait_irq;
        for (k = 0; k < 1200 && irq_status !== 1'b1; k++) tick(1);
    endtask
    // mode 0 frame from the tb as external master; 16x slower than ref_clk
    task automatic sframe(input logic [7:0] m, input int bits);
        #4.3 slave_enable_n = 0;
        tb_din = m[7];
        #200;
        for (int b = 0; b < bits; b++) begin
            clk_pin_in = 1;
            got = {got[6:0], data_out_pin};
            #80 clk_pin_in = 0;
            tb_din = (b < 7) ? m[6-b] : ~tb_din;
            #80;
        end
        slave_enable_n = 1;
        tb_din = ~tb_din;
        #200 tick(1);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200us mismatches++;
        print_verdict();
    end
    // ****************
    // scenarios
    // ****************
    initial begin
        tick(16);
        rst = 0;
        tick(1);
        chk("reset flags", {busy, tx_holding_full, irq_status, irq, data_out_pin}, 0);
        controller_on = 1;
        foreach (rows[i]) begin
            r = rows[i];
            {clock_polarity, clock_phase, word_size, clock_div} = {r.pol, r.pha, r.ws, r.div};
            nb = r.ws == 2'h0 ? 6'h08 : r.ws == 2'h1 ? 6'h10 : r.ws == 2'h2 ? 6'h20 : 6'h09;
            msk = nb == 6'h20 ? 32'hffff_ffff : nb == 6'h09 ? 32'hff : (32'h1 << nb) - 32'h1;
            ex = nb == 6'h09 ? {23'h0, ninth_bit_value, r.tx[7:0]} : r.tx & msk;
            {idle_level, irq_mask, mtx} = {i[0], i == 2, r.sx};
            tick(3);
            strobe(load);
            if (r.ws == `SFP_WORD_32) begin
                wr_data = {16'h0, r.tx[31:16]};
                strobe(serial_data_high_wr);
            end
            wr_data = r.tx;
            strobe(serial_data_low_wr);
            tick(1);
            chk("holding or busy", tx_holding_full | busy, 1);
            wait_irq();
            chk("received word", serial_data_out & msk, r.sx & msk);
            chk("sent word", mrx, ex);
            chk("pending", irq_pending_flag, 1);
            tick(3);
            chk("irq", irq, !irq_mask);
            chk("idle data", data_out_pin, idle_level);
            strobe(irq_clear);
            tick(1);
            chk("irq cleared", irq_status, 0);
            ninth_bit_value = ~ninth_bit_value;
            $display("row %0d done", i);
        end
        {word_size, clock_div, nb, mtx, irq_mask} = {`SFP_WORD_8, `SFP_DIV_8, 6'h08, 32'ha5, 1'b0};
        tick(3);
        strobe(load);
        wr_data = 32'h5c;
        strobe(serial_data_low_wr);
        tick(40);
        force_idle = 1;
        tick(2);
        chk("forced level", data_out_pin, idle_level);
        force_idle = 0;
        wait_irq();
        chk("buffer kept", serial_data_out[7:0], 8'ha5);
        strobe(irq_clear);
        strobe(load);
        strobe(serial_data_low_wr);
        tick(40);
        strobe(soft_reset);
        tick(2);
        chk("reset idles", {busy, data_out_pin}, {1'b0, idle_level});
        $display("force and reset done");
        {fifo_mode, clock_div, n} = {`SFP_FIFO_WRONLY, 2'h1, 0};
        tick(2);
        while (tx_holding_full !== 1'b1 && n < 12) begin
            wr_data = n;
            strobe(serial_data_low_wr);
            tick(1);
            n++;
        end
        chk("fifo full", {tx_holding_full, irq, n >= 4 && n <= 6}, 3'h5);
        for (k = 0; k < 800 && busy !== 1'b0; k++) tick(1);
        chk("drained", {busy, tx_holding_full, irq}, 3'h1);
        $display("write only done");
        fifo_mode = `SFP_FIFO_RDONLY;
        tick(4);
        chk("read starts", busy, 1);
        for (k = 0; k < 800 && busy !== 1'b0; k++) tick(1);
        chk("read stops", {busy, irq}, 2'h1);
        fifo_mode = `SFP_FIFO_BIDIR;
        strobe(irq_clear);
        tick(1);
        chk("unread keeps irq", irq, 1);
        for (n = 0; irq === 1'b1 && n < 8; n++) begin
            strobe(serial_data_low_rd);
            tick(1);
        end
        chk("words held", n, 4);
        $display("read only done");
        {fifo_mode, slave_select_cfg, slave_enable_ctrl} = {`SFP_FIFO_NONE, 2'h3};
        {clock_polarity, clock_phase, word_size} = 4'h0;
        tick(4);
        strobe(irq_clear);
        wr_data = 32'h3c;
        strobe(serial_data_low_wr);
        sframe(8'h18, 4);
        strobe(serial_data_low_wr);
        sframe(8'ha7, 8);
        wait_irq();
        chk("slave received", serial_data_out[7:0], 8'ha7);
        chk("slave sent", got, 8'h3c);
        $display("slave done");
        print_verdict();
    end
endmodule // sfp_core_tb
`default_nettype wire
